// *** dcdc_pwm_control.sv ***
// dc-dc converter pwm generator and current sense readback with axi4-lite
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dcdc_pwm_control (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [dcdc_pwm_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic [1:0]                         bresp,
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [dcdc_pwm_pkg::ADDR_W-1:0] araddr,
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    input  wire dcdc_pwm_pkg::sense_t          sense,
    input  wire logic [7:0]                    pulse_width_demand,
    input  wire logic                          feed_forward_polarity,
    input  wire logic                          calibration_done,
    output logic                               peak_monitor_calibrate,
    output logic                               converter_drive_pin,
    output logic                               feed_forward_pin
);
    import dcdc_pwm_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        return a == {2'b00, idx, 2'b00};
    endfunction

    // register bus state
    logic                aw_hold_reg, aw_hold_next;
    logic                w_hold_reg, w_hold_next;
    logic [ADDR_W-1:0]   awaddr_reg, awaddr_next;
    logic [7:0]          wbyte_reg, wbyte_next;
    logic                wlane_reg, wlane_next;
    logic                awready_reg, awready_next;
    logic                wready_reg, wready_next;
    logic                bvalid_reg, bvalid_next;
    logic [1:0]          bresp_reg, bresp_next;
    logic                arready_reg, arready_next;
    logic                rvalid_reg, rvalid_next;
    logic [31:0]         rdata_reg, rdata_next;
    logic [1:0]          rresp_reg, rresp_next;
    // software visible state
    logic [7:0]          period_reg, period_next;
    logic [4:0]          off_time_reg, off_time_next;
    logic                cal_reg, cal_next;
    logic                pol_reg;
    sense_t              sense_reg;
    // pwm engine state
    logic [ACC_W-1:0]    acc_reg, acc_next;
    logic                tick;
    logic [7:0]          cnt_reg, cnt_next;
    logic [7:0]          period_lat_reg, period_lat_next;
    logic [7:0]          pw_reg, pw_next;
    logic [4:0]          off_time_lat_reg, off_time_lat_next;
    logic [7:0]          on_lat_reg, on_lat_next;
    pwm_state_t          state_reg, state_next;
    logic                drive_reg, drive_next;
    logic                ff_reg, ff_next;
    logic                do_write;

    function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (hit(a, IDX_FIVE_CURRENT))
            v = sense_reg.fifth_transistor_current;
        if (hit(a, IDX_SIX_CURRENT))
            v = sense_reg.sixth_transistor_current;
        if (hit(a, IDX_PWM_PERIOD))
            v = period_reg;
        if (hit(a, IDX_SWITCH_DELAY))
            v = {cal_reg, 1'b0, pol_reg, off_time_reg};
        if (hit(a, IDX_PULSE_WIDTH))
            v = pw_reg;
        return v;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return hit(a, IDX_FIVE_CURRENT) || hit(a, IDX_SIX_CURRENT) ||
               hit(a, IDX_PWM_PERIOD) || hit(a, IDX_SWITCH_DELAY) ||
               hit(a, IDX_PULSE_WIDTH);
    endfunction

    // bus slave and register writes
    always_comb begin
        aw_hold_next = aw_hold_reg | (awvalid & awready_reg);
        w_hold_next  = w_hold_reg | (wvalid & wready_reg);
        awaddr_next  = (awvalid & awready_reg) ? awaddr : awaddr_reg;
        wbyte_next   = (wvalid & wready_reg) ? wdata[7:0] : wbyte_reg;
        wlane_next   = (wvalid & wready_reg) ? wstrb[0] : wlane_reg;
        bvalid_next  = bvalid_reg & ~bready;
        bresp_next   = bresp_reg;
        period_next  = period_reg;
        off_time_next    = off_time_reg;
        // done and start together: the start wins
        cal_next     = cal_reg & ~calibration_done;
        do_write     = aw_hold_next & w_hold_next & ~bvalid_reg;
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = mapped(awaddr_next) ? RESP_OKAY : RESP_SLVERR;
            if (wlane_next && hit(awaddr_next, IDX_PWM_PERIOD)) begin
                period_next = wbyte_next;
                period_next[PERIOD_FIXED_BIT] = 1'b1;
            end
            if (wlane_next && hit(awaddr_next, IDX_SWITCH_DELAY)) begin
                off_time_next = wbyte_next[OFF_TIME_W-1:0];
                if (wbyte_next[CAL_BIT])
                    cal_next = 1'b1;
            end
        end
        awready_next = ~aw_hold_next & ~bvalid_next;
        wready_next  = ~w_hold_next & ~bvalid_next;
        rvalid_next  = rvalid_reg & ~rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rdata_next  = {24'h000000, read_mux(araddr)};
            rresp_next  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        arready_next = ~rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wbyte_reg   <= 8'h00;
            wlane_reg   <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= RESP_OKAY;
            period_reg  <= PERIOD_RESET;
            off_time_reg    <= OFF_TIME_RESET;
            cal_reg     <= 1'b0;
            pol_reg     <= 1'b0;
            sense_reg   <= '0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg  <= w_hold_next;
            awaddr_reg  <= awaddr_next;
            wbyte_reg   <= wbyte_next;
            wlane_reg   <= wlane_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            period_reg  <= period_next;
            off_time_reg    <= off_time_next;
            cal_reg     <= cal_next;
            pol_reg     <= feed_forward_polarity;
            sense_reg   <= sense;
        end
    end

    // pwm engine: settings are latched only at a period boundary so a period
    // or off time write mid-period never produces a runt pulse; a calibration start drops drive one cycle after calibrate rises
    always_comb begin
        logic [8:0] pw_c;
        logic [8:0] floor_c;
        logic       reload;
        pw_c            = 9'h000;
        floor_c         = 9'h000;
        reload          = 1'b0;
        tick            = (acc_reg + CLK_ACC) >= STEP_ACC;
        acc_next        = tick ? ACC_W'(acc_reg + CLK_ACC - STEP_ACC)
                               : ACC_W'(acc_reg + CLK_ACC);
        cnt_next        = cnt_reg;
        period_lat_next = period_lat_reg;
        pw_next         = pw_reg;
        off_time_lat_next   = off_time_lat_reg;
        on_lat_next     = on_lat_reg;
        state_next      = state_reg;
        case (state_reg)
            PWM_CAL: begin
                // restart with an empty period to keep the off time whole
                if (!cal_reg) begin
                    cnt_next        = 8'h00;
                    on_lat_next     = 8'h00;
                    period_lat_next = period_reg;
                    state_next      = PWM_OFF;
                end
            end
            PWM_ON, PWM_OFF: begin
                if (cal_reg) begin
                    state_next = PWM_CAL;
                end else if (tick) begin
                    if (cnt_reg == period_lat_reg - 8'h01) begin
                        reload = 1'b1;
                    end else begin
                        cnt_next = cnt_reg + 8'h01;
                        if (cnt_next >= on_lat_reg)
                            state_next = PWM_OFF;
                    end
                end
            end
            default: state_next = PWM_OFF;
        endcase
        if (reload) begin
            // clamp so the off time never drops below its minimum
            pw_c = (pulse_width_demand > period_reg) ? {1'b0, period_reg}
                                                      : {1'b0, pulse_width_demand};
            floor_c = {4'h0, off_time_reg} + OFF_TIME_BASE;
            cnt_next        = 8'h00;
            period_lat_next = period_reg;
            pw_next         = pw_c[7:0];
            off_time_lat_next   = off_time_reg;
            on_lat_next     = (pw_c > floor_c) ? 8'(pw_c - floor_c)
                                               : 8'h00;
            state_next      = (on_lat_next != 8'h00) ? PWM_ON : PWM_OFF;
        end
        drive_next = (state_next == PWM_ON);
        ff_next    = pol_reg ? drive_next : ~drive_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg        <= '0;
            cnt_reg        <= 8'h00;
            period_lat_reg <= PERIOD_RESET;
            pw_reg         <= 8'h00;
            off_time_lat_reg   <= OFF_TIME_RESET;
            on_lat_reg     <= 8'h00;
            state_reg      <= PWM_OFF;
            drive_reg      <= 1'b0;
            ff_reg         <= 1'b0;
        end else begin
            acc_reg        <= acc_next;
            cnt_reg        <= cnt_next;
            period_lat_reg <= period_lat_next;
            pw_reg         <= pw_next;
            off_time_lat_reg   <= off_time_lat_next;
            on_lat_reg     <= on_lat_next;
            state_reg      <= state_next;
            drive_reg      <= drive_next;
            ff_reg         <= ff_next;
        end
    end

    assign awready                = awready_reg;
    assign wready                 = wready_reg;
    assign bvalid                 = bvalid_reg;
    assign bresp                  = bresp_reg;
    assign arready                = arready_reg;
    assign rvalid                 = rvalid_reg;
    assign rdata                  = rdata_reg;
    assign rresp                  = rresp_reg;
    assign peak_monitor_calibrate = cal_reg;
    assign converter_drive_pin    = drive_reg;
    assign feed_forward_pin       = ff_reg;

    // helper counters of step ticks in the current high and low runs
    logic [8:0] on_run_reg;
    logic [8:0] off_run_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_run_reg  <= 9'h000;
            off_run_reg <= 9'h000;
        end else begin
            if (!drive_reg && drive_next)
                on_run_reg <= 9'h000;
            else if (drive_reg && tick)
                on_run_reg <= on_run_reg + 9'h001;
            if (drive_reg && !drive_next)
                off_run_reg <= 9'h000;
            else if (!drive_reg && tick && off_run_reg != 9'h1ff)
                off_run_reg <= off_run_reg + 9'h001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence rd_at(logic [7:0] idx);
        arvalid && arready_reg && hit(araddr, idx);
    endsequence

    AST_FIVE_READ: assert property (rd_at(IDX_FIVE_CURRENT) |=>
        rvalid_reg && rdata_reg[7:0] == $past(sense_reg.fifth_transistor_current))
        else $error("fifth current readback wrong");
    AST_SIX_READ: assert property (rd_at(IDX_SIX_CURRENT) |=>
        rvalid_reg && rdata_reg[7:0] == $past(sense_reg.sixth_transistor_current))
        else $error("sixth current readback wrong");
    AST_PERIOD_COUNT: assert property (state_reg != PWM_CAL |->
        cnt_reg < period_lat_reg)
        else $error("step count beyond period");
    AST_PERIOD_BIT6: assert property (rd_at(IDX_PWM_PERIOD) |=>
        rdata_reg[PERIOD_FIXED_BIT] && rdata_reg[31:8] == 24'h000000)
        else $error("period bit 6 not one");
    AST_PERIOD_RANGE: assert property (period_lat_reg >= PERIOD_MIN)
        else $error("period below lower range");
    AST_CAL_START: assert property (do_write && wlane_next &&
        hit(awaddr_next, IDX_SWITCH_DELAY) && wbyte_next[CAL_BIT]
        |=> cal_reg ##1 (!drive_reg && state_reg == PWM_CAL))
        else $error("calibration did not start");
    AST_POLARITY: assert property (drive_reg |->
        ff_reg == $past(pol_reg))
        else $error("feed forward polarity wrong");
    AST_MIN_OFF: assert property ($rose(drive_reg) |->
        off_run_reg >= {4'h0, $past(off_time_lat_reg)} + OFF_TIME_BASE)
        else $error("off time shorter than minimum");
    AST_ON_TIME: assert property ($fell(drive_reg) && !$past(cal_reg) |->
        on_run_reg == {1'b0, pw_reg} - {4'h0, off_time_lat_reg} - OFF_TIME_BASE)
        else $error("on time does not match pulse width");
    AST_START_HIGH: assert property (tick && !cal_reg &&
        state_reg != PWM_CAL && cnt_reg == period_lat_reg - 8'h01
        |=> cnt_reg == 8'h00 && drive_reg == (on_lat_reg != 8'h00))
        else $error("period start drive wrong");
    AST_RSV_ZERO: assert property (rd_at(IDX_SWITCH_DELAY) |=>
        !rdata_reg[DELAY_RSV_BIT])
        else $error("reserved bit not zero");
endmodule // dcdc_pwm_control

// *** dcdc_pwm_pkg.sv ***
// constants and carrier types for the dc-dc pwm control and sense block
package dcdc_pwm_pkg;
    localparam int ADDR_W = 12;

    // printed offsets are register indices; byte address is four times that
    localparam logic [7:0] IDX_FIVE_CURRENT   = 8'h58;
    localparam logic [7:0] IDX_SIX_CURRENT    = 8'h59;
    localparam logic [7:0] IDX_PWM_PERIOD     = 8'h5c;
    localparam logic [7:0] IDX_SWITCH_DELAY   = 8'h5d;
    localparam logic [7:0] IDX_PULSE_WIDTH    = 8'h5e;

    localparam logic [7:0] PERIOD_RESET       = 8'hff;
    localparam logic [7:0] PERIOD_MIN         = 8'h40;
    localparam int         PERIOD_FIXED_BIT   = 6;
    localparam int         CAL_BIT            = 7;
    localparam int         DELAY_RSV_BIT      = 6;
    localparam int         POL_BIT            = 5;
    localparam int         OFF_TIME_W             = 5;
    localparam logic [4:0] OFF_TIME_RESET         = 5'h14;
    localparam logic [8:0] OFF_TIME_BASE          = 9'h004;

    localparam logic [1:0] RESP_OKAY          = 2'h0;
    localparam logic [1:0] RESP_SLVERR        = 2'h2;

    // one pwm step is 61.035 ns; made from 10 ns clock by a phase accumulator
    localparam int         STEP_PS            = 61035;
    localparam int         CLK_PERIOD_PS      = 10000;
    localparam int         ACC_W              = 17;
    localparam logic [16:0] STEP_ACC          = 17'(STEP_PS);
    localparam logic [16:0] CLK_ACC           = 17'(CLK_PERIOD_PS);

    typedef struct packed {
        logic [7:0] fifth_transistor_current;
        logic [7:0] sixth_transistor_current;
    } sense_t;

    typedef enum logic [2:0] {
        PWM_OFF = 3'b001,
        PWM_ON  = 3'b010,
        PWM_CAL = 3'b100
    } pwm_state_t;
endpackage

// *** power_stage_model.sv ***
// behavioural power stage and calibration engine seen from the drive pin
`timescale 1ns/1ps
module power_stage_model #(
    parameter int CAL_DELAY = 200
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        converter_drive_pin,
    input  wire logic        feed_forward_pin,
    input  wire logic        feed_forward_polarity,
    input  wire logic        peak_monitor_calibrate,
    output logic             calibration_done,
    output logic [15:0]      on_clks,
    output logic [15:0]      per_clks,
    output logic [15:0]      off_clks,
    output logic [15:0]      ff_errs
);
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] cal;
    logic        prev;
    logic        live;
    logic        pol_d;
    logic        pol_d2;

    always_ff @(posedge aclk) begin
        calibration_done <= 1'b0;
        // strap history runs through reset; the pin lags the strap by two
        pol_d  <= feed_forward_polarity;
        pol_d2 <= pol_d;
        if (!aresetn) begin
            {hi, lo, cal, on_clks, per_clks, off_clks, ff_errs} <= '0;
            prev <= 1'b0;
            live <= 1'b0;
        end else begin
            prev <= converter_drive_pin;
            live <= 1'b1;
            // routine finishes after a fixed wait, one-cycle done pulse
            if (peak_monitor_calibrate && cal == 16'(CAL_DELAY)) begin
                calibration_done <= 1'b1;
                cal <= '0;
            end else if (peak_monitor_calibrate) begin
                cal <= cal + 16'h0001;
            end else begin
                cal <= '0;
            end
            if (converter_drive_pin && !prev) begin
                per_clks <= hi + lo;
                off_clks <= lo;
                hi <= 16'h0001;
                lo <= '0;
            end else if (!converter_drive_pin && prev) begin
                on_clks <= hi;
                lo <= 16'h0001;
            end else if (converter_drive_pin) begin
                hi <= hi + 16'h0001;
            end else begin
                lo <= lo + 16'h0001;
            end
            // pin keeps its reset level one cycle, then tracks drive exactly
            if (live && feed_forward_pin !== (pol_d2 ?
                converter_drive_pin : !converter_drive_pin)) begin
                ff_errs <= ff_errs + 16'h0001;
            end
        end
    end
endmodule // power_stage_model

// *** tb_dcdc_pwm_control_and_sense.sv ***
// self-checking bench for the dc-dc pwm control and sense block
`timescale 1ns/1ps
module tb_dcdc_pwm_control_and_sense;
    import dcdc_pwm_pkg::*;
    logic              aclk, aresetn, awvalid, wvalid, bready;
    logic              arvalid, rready, awready, wready, bvalid;
    logic              arready, rvalid, pol, cal_done, calib, drv, ff;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    sense_t            sense;
    logic [7:0]        demand, pw;
    logic [15:0]       on_c, per_c, off_c, ff_errs;
    logic [1:0]        bq[$];
    logic [33:0]       rq[$];
    logic [7:0]        pv[4] = '{8'h00, 8'hbf, 8'h80, 8'h3f};
    logic [7:0]        cp[3] = '{8'h40, 8'hff, 8'hc0};
    logic [7:0]        ct[3] = '{8'h00, 8'h1f, 8'h05};
    logic [7:0]        cd[3] = '{8'h20, 8'hc0, 8'hff};
    int                n_errors, n_checks, cycles;

    dcdc_pwm_control dut_u (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .sense(sense), .pulse_width_demand(demand),
        .feed_forward_polarity(pol), .calibration_done(cal_done),
        .peak_monitor_calibrate(calib), .converter_drive_pin(drv),
        .feed_forward_pin(ff));
    power_stage_model stage_u (.aclk(aclk), .aresetn(aresetn),
        .converter_drive_pin(drv), .feed_forward_pin(ff),
        .feed_forward_polarity(pol), .peak_monitor_calibrate(calib),
        .calibration_done(cal_done), .on_clks(on_c), .per_clks(per_c),
        .off_clks(off_c), .ff_errs(ff_errs));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    function automatic logic [ADDR_W-1:0] ba(input logic [7:0] i);
        return ADDR_W'({i, 2'b00});
    endfunction

    // pwm step is not a whole number of clocks, so allow some jitter
    function automatic logic [33:0] near(input logic [15:0] m, input int s);
        int e = s * STEP_PS / CLK_PERIOD_PS;
        return 34'((int'(m) - e <= 8) && (e - int'(m) <= 8));
    endfunction

    task automatic check(input string n, input logic [33:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        bq.push_back(er);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        rq.push_back({er, 24'h000000, d});
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    always @(posedge aclk) begin
        if (bvalid && bready) check("bresp", 34'(bresp), 34'(bq.pop_front()));
        if (rvalid && rready) check("read", {rresp, rdata}, rq.pop_front());
    end

    // ceiling well above the roughly 12500 cycles the tests need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            final_report;
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, pol} = '0;
        {awaddr, araddr, wdata, wstrb, demand} = '0;
        sense = '0;
        void'($urandom(32'h6574));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ba(IDX_PWM_PERIOD), PERIOD_RESET, RESP_OKAY);
        rd(ba(IDX_SWITCH_DELAY), 8'h14, RESP_OKAY);
        rd(ba(IDX_PULSE_WIDTH), 8'h00, RESP_OKAY);
        rd(12'h000, 8'h00, RESP_SLVERR);
        wr(12'h004, 8'h55, 4'h1, RESP_SLVERR);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            sense <= (i == 0) ? 16'h00ff : 16'($urandom);
            repeat (3) @(posedge aclk);
            rd(ba(IDX_FIVE_CURRENT), sense[15:8], RESP_OKAY);
            rd(ba(IDX_SIX_CURRENT), sense[7:0], RESP_OKAY);
        end
        $display("test currents done");
        pv[3] = 8'($urandom);
        for (int i = 0; i < 4; i++) begin
            wr(ba(IDX_PWM_PERIOD), pv[i], 4'h1, RESP_OKAY);
            rd(ba(IDX_PWM_PERIOD), pv[i] | 8'h40, RESP_OKAY);
        end
        wr(ba(IDX_PWM_PERIOD), 8'h00, 4'h0, RESP_OKAY);
        rd(ba(IDX_PWM_PERIOD), pv[3] | 8'h40, RESP_OKAY);
        wr(ba(IDX_SWITCH_DELAY), 8'h7f, 4'h1, RESP_OKAY);
        rd(ba(IDX_SWITCH_DELAY), 8'h1f, RESP_OKAY);
        pol <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(ba(IDX_SWITCH_DELAY), 8'h3f, RESP_OKAY);
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            wr(ba(IDX_PWM_PERIOD), cp[i], 4'h1, RESP_OKAY);
            wr(ba(IDX_SWITCH_DELAY), ct[i], 4'h1, RESP_OKAY);
            demand <= cd[i];
            repeat (4000) @(posedge aclk);
            pw = (cd[i] > cp[i]) ? cp[i] : cd[i];
            rd(ba(IDX_PULSE_WIDTH), pw, RESP_OKAY);
            check("on_clks", near(on_c, pw - ct[i] - 4), 34'h1);
            check("per_clks", near(per_c, cp[i]), 34'h1);
            check("off_clks", near(off_c, cp[i] - pw + ct[i] + 4), 34'h1);
        end
        $display("test pwm done");
        wr(ba(IDX_SWITCH_DELAY), 8'h85, 4'h1, RESP_OKAY);
        rd(ba(IDX_SWITCH_DELAY), 8'ha5, RESP_OKAY);
        #1;
        check("calibrate", 34'(calib), 34'h1);
        check("drive", 34'(drv), 34'h0);
        repeat (300) @(posedge aclk);
        rd(ba(IDX_SWITCH_DELAY), 8'h25, RESP_OKAY);
        wr(ba(IDX_SWITCH_DELAY), 8'h05, 4'h1, RESP_OKAY);
        repeat (3) @(posedge aclk);
        #1;
        check("calibrate", 34'(calib), 34'h0);
        check("ff_errs", 34'(ff_errs), 34'h0);
        $display("test calibration done");
        final_report;
    end
endmodule // tb_dcdc_pwm_control_and_sense
